// *** verilog/loopmon_pkg.sv ***
/*
 * Shared constants for the loopback, monitor and jitter-peak control block.
 * Assumes a 100 MHz system clock and a 32-bit APB register port.
 */
package loopmon_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] loop_ctrl_off = 8'h00;
    localparam logic [7:0] pattern_detect_off = 8'h04;
    localparam logic [7:0] status_off = 8'h08;
    localparam logic [7:0] monitor_off = 8'h0c;
    localparam logic [7:0] jitter_ctrl_off = 8'h10;
    localparam logic [7:0] pos_peak_off = 8'h14;
    localparam logic [7:0] neg_peak_off = 8'h18;
    localparam logic [7:0] timer_int_off = 8'h1c;
    localparam logic [7:0] global_cfg_off = 8'h20;
    localparam logic [7:0] ja_ctrl_off = 8'h24;
    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int remote_bit = 1;
    localparam int digital_bit = 2;
    localparam int auto_bit = 3;
    localparam int pattern_detect_position_bit = 3;
    localparam int auto_stat_bit = 7;
    localparam int band_bit = 0;
    localparam int mode_bit = 1;
    localparam int stop_bit = 2;
    localparam int tmov_bit = 0;
    localparam int mon_w = 6;
    localparam int peak_w = 16;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int clk_mhz = 100;
    localparam int persist_ms = 5100;
    localparam int second_ms = 1000;
    localparam longint persist_cycles = longint'(persist_ms) * 1000 * clk_mhz + 1;
    localparam longint second_cycles = longint'(second_ms) * 1000 * clk_mhz;
    // ------------------------------------------------------------
    // Data path selections
    // ------------------------------------------------------------
    typedef enum logic [1:0] {sel_normal, sel_pattern, sel_looped, sel_ais} path_sel_t;
endpackage : loopmon_pkg

// *** verilog/persist_timer.sv ***
/*
 * Counts how long a level has been held; fires once it has lasted LIMIT+1 cycles.
 * Assumes a level from logic on the same clock.
 */
`timescale 1ns/1ps
module persist_timer #(
    parameter int W = 30,
    parameter logic [29:0] LIMIT = 30'd510000001
) (
    input wire logic clk_in, // System clock
    input wire logic rst_in, // Sync reset
    input wire logic level_in, // Level being timed
    output logic done_out // High while held long enough
);
    typedef struct packed {
        logic [W-1:0] count;
        logic done;
    } pt_state_t;
    pt_state_t st;
    pt_state_t next_st;
    always_comb begin
        next_st = st;
        if (!level_in) begin
            next_st.count = '0;
            next_st.done = 1'b0;
        end else if (st.count != LIMIT[W-1:0]) begin
            next_st.count = st.count + 1'b1;
        end else begin
            next_st.done = 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign done_out = st.done;
endmodule : persist_timer

// *** verilog/second_tick.sv ***
/*
 * Free-running divider that pulses once per PERIOD cycles while enabled.
 * Assumes the system clock is the master reference.
 */
`timescale 1ns/1ps
module second_tick #(
    parameter logic [27:0] PERIOD = 28'd100000000
) (
    input wire logic clk_in, // System clock
    input wire logic rst_in, // Sync reset
    input wire logic run_in, // Count while high
    output logic tick_out // One-cycle pulse
);
    typedef struct packed {
        logic [27:0] count;
        logic tick;
    } tk_state_t;
    tk_state_t st;
    tk_state_t next_st;
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!run_in) begin
            next_st.count = '0;
        end else if (st.count == PERIOD - 28'd1) begin
            next_st.count = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.count = st.count + 28'd1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign tick_out = st.tick;
endmodule : second_tick

// *** verilog/loopmon_ctrl.sv ***
/*
 * Loopback selection, channel-0 monitor control and jitter peak capture for one
 * line channel, with an APB register slave.
 * Assumes same-clock inband code detector levels, a bit-clock enable pulse,
 * and signed jitter samples from the receive jitter attenuator.
 */
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// (RQ1) Manual digital loop bit enables digital loopback.
// (RQ2) Auto digital loop armed only with detector on transmit and auto enable.
// (RQ3) Activate/deactivate codes held over 5.1 s enter/leave loop; status shows it.
// (RQ4) Clearing auto enable ends automatic digital loop at once.
// (RQ5) Software keeps detector position unchanged during auto loop.
// (RQ6) Digital loop feeds transmit data into receive decoder; line still driven.
// (RQ7) Loss-of-signal and AIS detectors keep watching real line data.
// (RQ8) Digital loop priorities: rx pattern over loop; tx pattern, loop, AIS.
// (RQ9) Automatic remote loop unavailable while digital loop is active.
// (RQ10) Dual loop: line data to shaper, system data to decoder only.
// (RQ11) Dual loop detector sources: rx violation/zeros/pattern on loop, rest fixed.
// (RQ12) Manual remote plus manual digital: rx pattern first; tx remote first; no AIS.
// (RQ13) Manual remote plus auto digital: no AIS, no tx pattern; rx pattern first.
// (RQ14) Nonzero six-bit monitor select picks monitored port for channel 0.
// (RQ15) Monitoring forces external impedance matching, ignoring termination field.
// (RQ16) Monitoring is non-intrusive; channel 0 keeps recovery and LOS active.
// (RQ17) Channel 0 may remote-loop while monitoring.
// (RQ18) Jitter meter runs only with rx attenuator on; band bit selects band.
// (RQ19) Peaks reported as high/low pairs; value over 16 gives UIpp.
// (RQ20) Timed mode: each second sets overflow flag, maskable, write one clears.
// (RQ21) Each second copies peaks to results and clears accumulators.
// (RQ22) Manual mode: stop bit rising edge copies peaks and clears accumulators.
// (RQ23) Loopback selections change only on the bit-clock enable.
module loopmon_ctrl #(
    parameter logic [29:0] PERSIST = 30'(loopmon_pkg::persist_cycles),
    parameter logic [27:0] SECOND = 28'(loopmon_pkg::second_cycles)
) (
    input wire logic clk_in, // 100 MHz clock
    input wire logic rst_in, // Sync reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic bit_en_in, // Bit-clock enable pulse
    input wire logic act_code_in, // Activate code seen on tx path
    input wire logic deact_code_in, // Deactivate code seen on tx path
    input wire logic remote_auto_req_in, // Auto remote request from rx detector
    input wire logic signed [15:0] jitter_in, // Jitter sample
    input wire logic jitter_vld_in, // Sample valid
    output loopmon_pkg::path_sel_t rx_sel_out, // Receive path source
    output loopmon_pkg::path_sel_t tx_sel_out, // Transmit path source
    output logic decoder_from_tx_out, // Decoder fed from transmit data
    output logic shaper_from_rx_out, // Shaper fed from receive data
    output logic rx_ais_gen_en_out, // Receive AIS generation allowed
    output logic tx_ais_gen_en_out, // Transmit AIS generation allowed
    output logic tx_pattern_gen_en_out, // Transmit pattern generation allowed
    output logic rx_err_det_on_loop_out, // Rx violation/zero/pattern detectors on loop
    output logic system_out_en_out, // Receive data reaches system side
    output logic line_out_en_out, // Transmit data reaches line
    output logic [5:0] monitor_select_out, // Monitored port for channel 0
    output logic ext_match_out, // Channel 0 external impedance matching
    output logic [2:0] rx_term_out, // Effective termination select
    output logic jitter_band_select_out, // Measured jitter band
    output logic tmov_irq_out // Timer overflow interrupt
);
    import loopmon_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] loop_ctrl;
        logic pattern_detect_position;
        logic [5:0] monitor_select;
        logic [2:0] rx_term;
        logic [2:0] jit_ctrl;
        logic rx_ja_en;
        logic pattern_gen;
        logic tx_ais_req;
        logic auto_active;
        logic timer_overflow_flag;
        logic timer_overflow_mask;
        logic [15:0] pos_acc;
        logic [15:0] neg_acc;
        logic [15:0] pos_peak;
        logic [15:0] neg_peak;
        logic [31:0] rdata;
        logic ready;
        logic err;
        path_sel_t rx_sel;
        path_sel_t tx_sel;
        logic [7:0] path_flags;
        logic irq;
        logic ext_match;
        logic [2:0] rx_term_eff;
    } lm_state_t;
    lm_state_t st;
    lm_state_t next_st;

    logic act_held;
    logic deact_held;
    logic sec_tick;

    persist_timer #(.W(30), .LIMIT(PERSIST)) act_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .level_in(act_code_in),
        .done_out(act_held)
    );
    persist_timer #(.W(30), .LIMIT(PERSIST)) deact_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .level_in(deact_code_in),
        .done_out(deact_held)
    );
    second_tick #(.PERIOD(SECOND)) one_second (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(st.jit_ctrl[mode_bit] && st.rx_ja_en),
        .tick_out(sec_tick)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Read-only and unmapped words refuse writes
    function automatic logic wr_ok(input logic [7:0] a);
        wr_ok = a <= ja_ctrl_off && a[1:0] == 2'h0 && a != status_off && a != pos_peak_off && a != neg_peak_off;
    endfunction : wr_ok

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic wr;
    logic rd;
    logic armed;
    logic dig_on;
    logic rem_on;
    logic stop_rise;
    logic capture;
    logic [31:0] rv;
    always_comb begin
        next_st = st;
        // Writes land at the access edge, where pready is seen high
        wr = psel && penable && pwrite && st.ready;
        rd = psel && !penable && !pwrite;
        rv = 32'h0;
        next_st.ready = psel && !penable;
        // Decided at setup so it stands beside pready
        next_st.err = psel && !penable && pwrite && !wr_ok(paddr);
        stop_rise = 1'b0;
        if (wr) begin
            if (hit(paddr, loop_ctrl_off)) begin
                next_st.loop_ctrl = pwdata[7:0];
            end else if (hit(paddr, pattern_detect_off)) begin
                next_st.pattern_detect_position = pwdata[pattern_detect_position_bit];
                next_st.pattern_gen = pwdata[0];
                next_st.tx_ais_req = pwdata[1];
            end else if (hit(paddr, monitor_off)) begin
                next_st.monitor_select = pwdata[5:0];
                next_st.rx_term = pwdata[10:8];
            end else if (hit(paddr, jitter_ctrl_off)) begin
                stop_rise = pwdata[stop_bit] && !st.jit_ctrl[stop_bit]; // [RQ22]
                next_st.jit_ctrl = pwdata[2:0];
            end else if (hit(paddr, global_cfg_off)) begin
                next_st.timer_overflow_mask = pwdata[tmov_bit];
            end else if (hit(paddr, ja_ctrl_off)) begin
                next_st.rx_ja_en = pwdata[0];
            end
        end
        if (rd) begin
            case (paddr)
                loop_ctrl_off: rv = {24'h0, st.loop_ctrl};
                pattern_detect_off: rv = {28'h0, st.pattern_detect_position, 1'b0, st.tx_ais_req, st.pattern_gen};
                status_off: rv = {24'h0, st.auto_active, 7'h0}; // [RQ3]
                monitor_off: rv = {21'h0, st.rx_term, 2'h0, st.monitor_select};
                jitter_ctrl_off: rv = {29'h0, st.jit_ctrl};
                pos_peak_off: rv = {16'h0, st.pos_peak}; // [RQ19]
                neg_peak_off: rv = {16'h0, st.neg_peak}; // [RQ19]
                timer_int_off: rv = {31'h0, st.timer_overflow_flag};
                global_cfg_off: rv = {31'h0, st.timer_overflow_mask};
                ja_ctrl_off: rv = {31'h0, st.rx_ja_en};
                default: next_st.err = 1'b1;
            endcase
            next_st.rdata = rv;
        end
        // Auto digital loop
        armed = st.pattern_detect_position && st.loop_ctrl[auto_bit]; // [RQ2]
        if (!armed) begin
            next_st.auto_active = 1'b0; // [RQ4]
        end else if (act_held) begin
            next_st.auto_active = 1'b1; // [RQ3]
        end else if (deact_held) begin
            next_st.auto_active = 1'b0; // [RQ3]
        end
        // Monitoring hides the termination field
        next_st.ext_match = |next_st.monitor_select; // [RQ15]
        next_st.rx_term_eff = next_st.ext_match ? 3'h0 : next_st.rx_term; // [RQ15]
        // Jitter meter, only with attenuator on
        capture = st.rx_ja_en && (st.jit_ctrl[mode_bit] ? sec_tick : stop_rise); // [RQ18] [RQ21] [RQ22]
        if (st.rx_ja_en && jitter_vld_in) begin
            if (jitter_in > $signed(st.pos_acc)) begin
                next_st.pos_acc = jitter_in;
            end
            if (-jitter_in > $signed(st.neg_acc)) begin
                next_st.neg_acc = 16'(-jitter_in);
            end
        end
        if (capture) begin
            next_st.pos_peak = st.pos_acc;
            next_st.neg_peak = st.neg_acc;
            next_st.pos_acc = '0;
            next_st.neg_acc = '0;
        end
        // Set wins over write-one-clear
        if (wr && hit(paddr, timer_int_off) && pwdata[tmov_bit]) begin
            next_st.timer_overflow_flag = 1'b0; // [RQ20]
        end
        if (st.jit_ctrl[mode_bit] && sec_tick && st.rx_ja_en) begin
            next_st.timer_overflow_flag = 1'b1; // [RQ20]
        end
        next_st.irq = next_st.timer_overflow_flag && !next_st.timer_overflow_mask;
        // Data path selection on the bit enable only
        dig_on = st.loop_ctrl[digital_bit] || st.auto_active; // [RQ1]
        // Auto remote loop blocked inside a digital loop
        rem_on = st.loop_ctrl[remote_bit] || (remote_auto_req_in && !dig_on); // [RQ9] [RQ17]
        if (bit_en_in) begin // [RQ23]
            next_st.rx_sel = st.pattern_gen ? sel_pattern : (dig_on ? sel_looped : sel_normal); // [RQ8]
            if (rem_on && dig_on) begin
                if (st.auto_active && !st.loop_ctrl[digital_bit]) begin
                    next_st.tx_sel = sel_looped; // [RQ13]
                end else begin
                    next_st.tx_sel = sel_looped; // [RQ12]
                end
            end else if (rem_on) begin
                next_st.tx_sel = st.pattern_gen ? sel_pattern : sel_looped;
            end else if (dig_on) begin
                next_st.tx_sel = st.pattern_gen ? sel_pattern : sel_normal; // [RQ8]
            end else begin
                next_st.tx_sel = st.pattern_gen ? sel_pattern : (st.tx_ais_req ? sel_ais : sel_normal);
            end
            next_st.path_flags[0] = dig_on; // [RQ6]
            next_st.path_flags[1] = rem_on; // [RQ10]
            next_st.path_flags[2] = !dig_on; // [RQ8] [RQ12]
            next_st.path_flags[3] = !rem_on; // [RQ12]
            next_st.path_flags[4] = !(rem_on && dig_on && st.auto_active && !st.loop_ctrl[digital_bit]); // [RQ13]
            next_st.path_flags[5] = dig_on; // [RQ11] [RQ7]
            next_st.path_flags[6] = !(rem_on && dig_on); // [RQ10]
            next_st.path_flags[7] = !(rem_on && dig_on); // [RQ10] [RQ6]
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '0;
            st.path_flags <= 8'h1c;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;
    assign rx_sel_out = st.rx_sel;
    assign tx_sel_out = st.tx_sel;
    assign decoder_from_tx_out = st.path_flags[0];
    assign shaper_from_rx_out = st.path_flags[1];
    assign rx_ais_gen_en_out = st.path_flags[2];
    assign tx_ais_gen_en_out = st.path_flags[3];
    assign tx_pattern_gen_en_out = st.path_flags[4];
    assign rx_err_det_on_loop_out = st.path_flags[5];
    assign system_out_en_out = st.path_flags[6];
    assign line_out_en_out = st.path_flags[7];
    // Monitored side keeps running; only channel 0 input changes
    assign monitor_select_out = st.monitor_select; // [RQ14] [RQ16]
    assign ext_match_out = st.ext_match;
    assign rx_term_out = st.rx_term_eff;
    assign jitter_band_select_out = st.jit_ctrl[band_bit]; // [RQ18]
    assign tmov_irq_out = st.irq; // [RQ20]

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sel_hold_a: assert property ( // [RQ23]
        @(posedge clk_in) disable iff (rst_in)
        !bit_en_in |=> $stable(rx_sel_out) && $stable(tx_sel_out))
        else $error("path select moved off the bit enable");
    dig_rx_sel_a: assert property ( // [RQ8]
        @(posedge clk_in) disable iff (rst_in)
        bit_en_in && st.loop_ctrl[digital_bit] && !st.pattern_gen |=> rx_sel_out == sel_looped)
        else $error("digital loop missing on receive path");
    remote_block_a: assert property ( // [RQ9]
        @(posedge clk_in) disable iff (rst_in)
        bit_en_in && st.loop_ctrl[digital_bit] && !st.loop_ctrl[remote_bit] |=> !shaper_from_rx_out)
        else $error("remote loop inside a digital loop");
    dual_ais_off_a: assert property ( // [RQ12]
        @(posedge clk_in) disable iff (rst_in)
        bit_en_in && st.loop_ctrl[digital_bit] && st.loop_ctrl[remote_bit]
        |=> !rx_ais_gen_en_out && !tx_ais_gen_en_out)
        else $error("ais generation left on in dual loop");
    tmov_set_a: assert property ( // [RQ20]
        @(posedge clk_in) disable iff (rst_in)
        st.jit_ctrl[mode_bit] && st.rx_ja_en && sec_tick |=> st.timer_overflow_flag)
        else $error("overflow flag not set on expiry");
    monitor_match_a: assert property ( // [RQ15]
        @(posedge clk_in) disable iff (rst_in)
        |monitor_select_out |-> ext_match_out && rx_term_out == 3'h0)
        else $error("monitoring without external matching");
endmodule : loopmon_ctrl

// *** tb/line_side_model.sv ***
/*
 * Stand-in for the framer and line coder: bit-clock enable, inband code
 * levels from the transmit-path detector and jitter samples.
 * Assumes the bench sets code requests and the jitter amplitude.
 */
`timescale 1ns/1ps
module line_side_model #(
    parameter int DIV = 8
) (
    input wire logic clk_in, // System clock
    input wire logic rst_in, // Sync reset
    input wire logic act_req_in, // Send activate code
    input wire logic deact_req_in, // Send deactivate code
    input wire logic [15:0] amp_in, // Jitter amplitude
    output logic bit_en_out, // Bit-clock enable
    output logic act_code_out, // Activate code seen
    output logic deact_code_out, // Deactivate code seen
    output logic signed [15:0] jitter_out, // Jitter sample
    output logic jitter_vld_out // Sample valid
);
    int cnt;
    logic neg;
    always_ff @(posedge clk_in) begin
        bit_en_out <= 1'h0;
        jitter_vld_out <= 1'h0;
        // Garbage between samples, so a meter ignoring valid gets caught
        jitter_out <= ~jitter_out;
        if (rst_in) begin
            cnt <= 0;
            neg <= 1'h0;
            act_code_out <= 1'h0;
            deact_code_out <= 1'h0;
            jitter_out <= 16'h0000;
        end else if (cnt == DIV - 1) begin
            cnt <= 0;
            bit_en_out <= 1'h1;
            // Codes only move on symbol boundaries
            act_code_out <= act_req_in;
            deact_code_out <= deact_req_in;
            neg <= ~neg;
            jitter_out <= neg ? -$signed(amp_in) : $signed(amp_in);
            jitter_vld_out <= 1'h1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : line_side_model

// *** tb/loopback_monitor_jitter_ctrl_bench.sv ***
/*
 * Self-checking bench for the loopback, monitor and jitter-peak block.
 * Assumes shortened persist and one-second counts (100 and 50 cycles).
 */
`timescale 1ns/1ps
module loopback_monitor_jitter_ctrl_bench;
    import loopmon_pkg::*;
    logic clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic act_req = 1'h0;
    logic deact_req = 1'h0;
    logic remote_req = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] amp = 16'h0000;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, bit_en, act_code, deact_code, jvld, dec_tx, shp_rx, rx_ais, tx_ais;
    logic tx_pat, rx_det, sys_en, line_en, ext_match, band, irq;
    path_sel_t rx_sel, tx_sel;
    logic [5:0] mon_sel;
    logic [2:0] rx_term;
    logic signed [15:0] jit;
    int bad_count = 0;
    int comparisons = 0;

    loopmon_ctrl #(.PERSIST(30'h64), .SECOND(28'h32)) dut (.clk_in(clk_in), .rst_in(rst_in),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_en_in(bit_en),
        .act_code_in(act_code), .deact_code_in(deact_code), .remote_auto_req_in(remote_req),
        .jitter_in(jit), .jitter_vld_in(jvld), .rx_sel_out(rx_sel), .tx_sel_out(tx_sel),
        .decoder_from_tx_out(dec_tx), .shaper_from_rx_out(shp_rx), .rx_ais_gen_en_out(rx_ais),
        .tx_ais_gen_en_out(tx_ais), .tx_pattern_gen_en_out(tx_pat), .rx_err_det_on_loop_out(rx_det),
        .system_out_en_out(sys_en), .line_out_en_out(line_en), .monitor_select_out(mon_sel),
        .ext_match_out(ext_match), .rx_term_out(rx_term), .jitter_band_select_out(band),
        .tmov_irq_out(irq));
    line_side_model far (.clk_in(clk_in), .rst_in(rst_in), .act_req_in(act_req),
        .deact_req_in(deact_req), .amp_in(amp), .bit_en_out(bit_en), .act_code_out(act_code),
        .deact_code_out(deact_code), .jitter_out(jit), .jitter_vld_out(jvld));

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk_in);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'h1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'h1);
        rdata = prdata;
        check(pslverr, 1'h0, "apb error");
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        apb(1'h1, addr, wd);
    endtask : wr

    task automatic rd(input logic [7:0] addr);
        apb(1'h0, addr, 32'h0);
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge bit_en);
        @(negedge clk_in);
    endtask : settle

    task automatic poll(input logic [7:0] addr, input int b, input logic exp);
        int n;
        n = 0;
        do begin
            rd(addr);
            n++;
        end while (rdata[b] !== exp && n < 100);
        check(rdata[b], exp, "polled bit");
    endtask : poll

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic manual_loop();
        wr(loop_ctrl_off, 32'h4);
        settle();
        check(dec_tx, 1'h1, "decoder fed from tx");
        check(line_en, 1'h1, "line still driven");
        check(rx_ais, 1'h0, "rx ais in loop");
        check(rx_sel, sel_looped, "rx looped");
        check(tx_sel, sel_normal, "tx passes");
        @(posedge clk_in);
        remote_req <= 1'h1;
        settle();
        check(shp_rx, 1'h0, "auto remote in loop");
        @(posedge clk_in);
        remote_req <= 1'h0;
        wr(loop_ctrl_off, 32'h6);
        settle();
        check(shp_rx, 1'h1, "dual shaper");
        check({sys_en, line_en}, 2'h0, "dual outputs cut");
        check(rx_det, 1'h1, "dual rx detectors");
        check({rx_ais, tx_ais}, 2'h0, "dual ais");
        wr(loop_ctrl_off, 32'h0);
        settle();
        check(dec_tx, 1'h0, "loop left");
    endtask : manual_loop

    task automatic auto_loop();
        wr(loop_ctrl_off, 32'h8);
        act_req <= 1'h1;
        repeat (300) @(posedge clk_in);
        rd(status_off);
        check(rdata[auto_stat_bit], 1'h0, "armed on rx side");
        wr(pattern_detect_off, 32'h8);
        poll(status_off, auto_stat_bit, 1'h1);
        settle();
        check(dec_tx, 1'h1, "auto loop path");
        @(posedge clk_in);
        act_req <= 1'h0;
        deact_req <= 1'h1;
        poll(status_off, auto_stat_bit, 1'h0);
        deact_req <= 1'h0;
        act_req <= 1'h1;
        poll(status_off, auto_stat_bit, 1'h1);
        wr(loop_ctrl_off, 32'ha);
        settle();
        check({rx_ais, tx_ais, tx_pat}, 3'h0, "remote plus auto");
        wr(loop_ctrl_off, 32'h2);
        rd(status_off);
        check(rdata[auto_stat_bit], 1'h0, "auto cleared");
        act_req <= 1'h0;
        wr(loop_ctrl_off, 32'h0);
        wr(pattern_detect_off, 32'h0);
    endtask : auto_loop

    task automatic monitor();
        wr(monitor_off, 32'h515);
        settle();
        check(mon_sel, 6'h15, "monitor select");
        check({ext_match, rx_term}, 4'h8, "forced matching");
        wr(loop_ctrl_off, 32'h2);
        settle();
        check(shp_rx, 1'h1, "remote while monitoring");
        wr(loop_ctrl_off, 32'h0);
        wr(monitor_off, 32'h500);
        settle();
        check({ext_match, rx_term}, 4'h5, "monitor off");
    endtask : monitor

    task automatic jitter();
        wr(ja_ctrl_off, 32'h1);
        wr(jitter_ctrl_off, 32'h1);
        amp <= 16'h0025;
        @(negedge clk_in);
        check(band, 1'h1, "band select");
        settle();
        @(posedge clk_in);
        amp <= 16'h0011;
        settle();
        @(posedge clk_in);
        amp <= 16'h0003;
        wr(jitter_ctrl_off, 32'h5);
        rd(pos_peak_off);
        check(rdata[15:0], 16'h0025, "manual peak");
        rd(neg_peak_off);
        check(rdata[15:0], 16'h0025, "manual negative peak");
        settle();
        wr(jitter_ctrl_off, 32'h1);
        wr(jitter_ctrl_off, 32'h5);
        rd(pos_peak_off);
        check(rdata[15:0], 16'h0003, "fresh round");
        wr(global_cfg_off, 32'h0);
        amp <= 16'h0009;
        wr(jitter_ctrl_off, 32'h2);
        poll(timer_int_off, tmov_bit, 1'h1);
        check(irq, 1'h1, "irq raised");
        wr(timer_int_off, 32'h1);
        rd(timer_int_off);
        check(rdata[tmov_bit], 1'h0, "flag cleared");
        rd(pos_peak_off);
        check(rdata[15:0], 16'h0009, "timed peak");
        wr(global_cfg_off, 32'h1);
        poll(timer_int_off, tmov_bit, 1'h1);
        check(irq, 1'h0, "irq masked");
    endtask : jitter

    initial begin
        #200000;
        bad_count++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'h0;
        manual_loop();
        auto_loop();
        monitor();
        jitter();
        test_done();
    end
endmodule : loopback_monitor_jitter_ctrl_bench
